// ### pkg/hbd_pkg.sv
// constants, pin bundle and state type for the half-bridge serial fault controller
// assumes one system clock; every pin enters through the synchroniser in hbd_spi_fault
package hbd_pkg;

    localparam int HBD_WORD_W    = 16;
    localparam int HBD_NUM_BR    = 12;
    localparam int HBD_GRP_W     = 6;
    localparam int HBD_CNT_W     = 4;

    // command word fields
    localparam int CMD_SRR_BIT   = 15;
    localparam int CMD_SEL_BIT   = 14;
    localparam int CMD_UNDERLOAD_SHUTDOWN_ENABLE_BIT = 13;
    localparam int CMD_EN_LSB    = 7;
    localparam int CMD_CNF_LSB   = 1;
    localparam int CMD_OVERVOLTAGE_LOCKOUT_ENABLE_BIT  = 0;

    // status word fields
    localparam int STA_TSD_BIT   = 15;
    localparam int STA_OCS_BIT   = 14;
    localparam int STA_ULD_BIT   = 13;
    localparam int STA_OST_LSB   = 7;
    localparam int STA_CST_LSB   = 1;
    localparam int STA_PSF_BIT   = 0;

    // values after reset, and the high and low group masks
    localparam logic [15:0] HBD_WORD_RST = 16'h0000;
    localparam logic [11:0] HBD_BR_RST   = 12'h000;
    localparam logic [11:0] HBD_HI_GRP   = 12'hFC0;
    localparam logic [11:0] HBD_LO_GRP   = 12'h03F;
    localparam logic [3:0]  HBD_CNT_RST  = 4'h0;
    localparam logic [7:0]  HBD_EDGE_RST = 8'h00;

    typedef struct packed {
        logic        en;
        logic        csn;
        logic        sclk;
        logic        si;
        logic        s_ov;
        logic        s_uv;
        logic        tw;
        logic [11:0] thermal_shutdown_flag;
        logic [11:0] overcurrent_flag;
        logic [11:0] underload_flag;
    } hbd_pins_t;

    localparam hbd_pins_t HBD_PINS_RST = '{csn: 1'b1, default: '0};

    typedef enum logic [1:0] {
        HBD_SLEEP = 2'h0,
        HBD_IDLE  = 2'h1,
        HBD_FRAME = 2'h2
    } hbd_spi_state_t;

endpackage : hbd_pkg

// ### rtl/hbd_spi_fault.sv
// serial command/status slave and fault protection for twelve half-bridges
// assumes all pins asynchronous to SYS_CLK_I and serial clock well below clock/4
module hbd_spi_fault
    import hbd_pkg::*;
(
    input  wire logic        SYS_CLK_I,
    input  wire logic        RST_N_I,
    input  wire logic        EN_I,
    input  wire logic        CHIP_SELECT_N_I,
    input  wire logic        SCLK_I,
    input  wire logic        SI_I,
    input  wire logic        SUPPLY_OVERVOLTAGE_I,
    input  wire logic        SUPPLY_UNDERVOLTAGE_I,
    input  wire logic        THERMAL_WARNING_I,
    input  wire logic [11:0] THERMAL_FAULT_I,
    input  wire logic [11:0] OVERCURRENT_I,
    input  wire logic [11:0] UNDERLOAD_I,
    output logic             SO_O,
    output logic             SO_OE_O,
    output logic [11:0]      BRIDGE_OUTPUT_EN_O,
    output logic [11:0]      BRIDGE_OUTPUT_HIGH_O,
    output logic             THERMAL_WARNING_O
);

    // group helpers
    function automatic logic [11:0] grp_mask(input logic g);
        return g ? HBD_HI_GRP : HBD_LO_GRP;
    endfunction

    function automatic logic [11:0] grp_place(input logic g, input logic [5:0] v);
        return g ? {v, 6'h00} : {6'h00, v};
    endfunction

    function automatic logic [5:0] grp_pick(input logic g, input logic [11:0] v);
        return g ? v[11:6] : v[5:0];
    endfunction

    hbd_pins_t      pin_raw;
    hbd_pins_t      meta_r;
    hbd_pins_t      sync_r;
    hbd_pins_t      prev_r;
    hbd_spi_state_t state_r;
    hbd_spi_state_t state_nxt;
    logic           awake;
    logic           cs_fall;
    logic           cs_rise;
    logic           sclk_rise;
    logic           sclk_fall;
    logic           in_frame;
    logic           frame_start;
    logic           commit;
    logic [15:0]    rx_r;
    logic [15:0]    tx_r;
    logic [3:0]     cnt_r;
    logic           got16_r;
    logic           sel_r;
    logic           overvoltage_lockout_enable_r;
    logic [1:0]     underload_shutdown_enable_r;
    logic [11:0]    cfg_en_r;
    logic [11:0]    cfg_hi_r;
    logic [11:0]    tsd_lat_r;
    logic [11:0]    ocs_lat_r;
    logic [11:0]    uld_flag_r;
    logic [11:0]    uld_off_r;
    logic [11:0]    srr_clr;
    logic [11:0]    underload_shutdown_enable_mask;
    logic [11:0]    out_en_nxt;
    logic           lockout;
    logic [15:0]    status_word;
    logic [7:0]     edges_r;

    // two-stage synchroniser for every pin
    assign pin_raw = '{en: EN_I, csn: CHIP_SELECT_N_I, sclk: SCLK_I, si: SI_I,
                       s_ov: SUPPLY_OVERVOLTAGE_I, s_uv: SUPPLY_UNDERVOLTAGE_I,
                       tw: THERMAL_WARNING_I, thermal_shutdown_flag: THERMAL_FAULT_I,
                       overcurrent_flag: OVERCURRENT_I, underload_flag: UNDERLOAD_I};

    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            meta_r <= HBD_PINS_RST;
            sync_r <= HBD_PINS_RST;
            prev_r <= HBD_PINS_RST;
        end else begin
            meta_r <= pin_raw;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign awake     = sync_r.en;
    assign cs_fall   = prev_r.csn & ~sync_r.csn;
    assign cs_rise   = ~prev_r.csn & sync_r.csn;
    assign sclk_rise = ~prev_r.sclk & sync_r.sclk;
    assign sclk_fall = prev_r.sclk & ~sync_r.sclk;

    // frame state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            HBD_SLEEP: begin
                if (awake) state_nxt = HBD_IDLE;
            end
            HBD_IDLE: begin
                if (!awake) state_nxt = HBD_SLEEP;
                else if (cs_fall) state_nxt = HBD_FRAME;
            end
            HBD_FRAME: begin
                if (!awake) state_nxt = HBD_SLEEP;
                else if (cs_rise) state_nxt = HBD_IDLE;
            end
            default: state_nxt = HBD_SLEEP;
        endcase
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) state_r <= HBD_SLEEP;
        else          state_r <= state_nxt;
    end

    assign in_frame    = (state_r == HBD_FRAME);
    assign frame_start = (state_r == HBD_IDLE) & awake & cs_fall;
    // whole multiple of 16 bits, taken at select rise
    assign commit      = in_frame & awake & cs_rise & got16_r & (cnt_r == HBD_CNT_RST);

    // shift registers: msb first, sample on rise, shift on fall
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I || !awake) begin
            rx_r    <= HBD_WORD_RST;
            tx_r    <= HBD_WORD_RST;
            cnt_r   <= HBD_CNT_RST;
            got16_r <= 1'b0;
        end else if (frame_start) begin
            tx_r    <= status_word;
            cnt_r   <= HBD_CNT_RST;
            got16_r <= 1'b0;
        end else if (in_frame) begin
            if (sclk_rise) begin
                rx_r  <= {rx_r[14:0], sync_r.si};
                cnt_r <= cnt_r + 4'h1;
                if (cnt_r == 4'hF) got16_r <= 1'b1;
            end
            if (sclk_fall) begin
                tx_r <= {tx_r[14:0], rx_r[0]};
            end
        end
    end

    assign SO_O    = tx_r[15];
    assign SO_OE_O = in_frame;

    // command registers, accepted even during lockout
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I || !awake) begin
            sel_r    <= 1'b0;
            overvoltage_lockout_enable_r   <= 1'b0;
            underload_shutdown_enable_r  <= 2'h0;
            cfg_en_r <= HBD_BR_RST;
            cfg_hi_r <= HBD_BR_RST;
        end else if (commit) begin
            sel_r   <= rx_r[CMD_SEL_BIT];
            overvoltage_lockout_enable_r  <= rx_r[CMD_OVERVOLTAGE_LOCKOUT_ENABLE_BIT];
            underload_shutdown_enable_r[rx_r[CMD_SEL_BIT]] <= rx_r[CMD_UNDERLOAD_SHUTDOWN_ENABLE_BIT];
            cfg_en_r <= (cfg_en_r & ~grp_mask(rx_r[CMD_SEL_BIT]))
                      | grp_place(rx_r[CMD_SEL_BIT], rx_r[CMD_EN_LSB +: 6]);
            cfg_hi_r <= (cfg_hi_r & ~grp_mask(rx_r[CMD_SEL_BIT]))
                      | grp_place(rx_r[CMD_SEL_BIT], rx_r[CMD_CNF_LSB +: 6]);
        end
    end

    assign srr_clr    = (commit && rx_r[CMD_SRR_BIT]) ? grp_mask(rx_r[CMD_SEL_BIT])
                                                        : HBD_BR_RST;
    assign underload_shutdown_enable_mask = {{6{underload_shutdown_enable_r[1]}}, {6{underload_shutdown_enable_r[0]}}};

    // latched protection faults, a new event wins over the clear
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I || !awake) begin
            tsd_lat_r  <= HBD_BR_RST;
            ocs_lat_r  <= HBD_BR_RST;
            uld_flag_r <= HBD_BR_RST;
            uld_off_r  <= HBD_BR_RST;
        end else begin
            tsd_lat_r  <= (tsd_lat_r & ~srr_clr) | sync_r.thermal_shutdown_flag;
            ocs_lat_r  <= (ocs_lat_r & ~srr_clr) | sync_r.overcurrent_flag;
            uld_flag_r <= (uld_flag_r & ~srr_clr) | sync_r.underload_flag;
            uld_off_r  <= (uld_off_r & ~srr_clr) | (sync_r.underload_flag & underload_shutdown_enable_mask);
        end
    end

    // supply lockout, non-latched; warning never reaches the bridge outputs
    assign lockout    = sync_r.s_uv | (sync_r.s_ov & overvoltage_lockout_enable_r);
    assign out_en_nxt = cfg_en_r & ~tsd_lat_r & ~ocs_lat_r & ~uld_off_r
                      & {12{~lockout & awake}};

    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            BRIDGE_OUTPUT_EN_O   <= HBD_BR_RST;
            BRIDGE_OUTPUT_HIGH_O <= HBD_BR_RST;
            THERMAL_WARNING_O    <= 1'b0;
        end else begin
            BRIDGE_OUTPUT_EN_O   <= out_en_nxt;
            BRIDGE_OUTPUT_HIGH_O <= cfg_hi_r;
            THERMAL_WARNING_O    <= sync_r.tw & awake;
        end
    end

    // status snapshot: TSD and supply bits for all bridges, other fields for the group picked by the previous frame
    always_comb begin
        status_word                    = HBD_WORD_RST;
        status_word[STA_TSD_BIT]       = |tsd_lat_r;
        status_word[STA_OCS_BIT]       = |(ocs_lat_r & grp_mask(sel_r));
        status_word[STA_ULD_BIT]       = |(uld_flag_r & grp_mask(sel_r));
        status_word[STA_OST_LSB +: 6]  = grp_pick(sel_r, BRIDGE_OUTPUT_EN_O);
        status_word[STA_CST_LSB +: 6]  = grp_pick(sel_r, cfg_hi_r);
        status_word[STA_PSF_BIT]       = sync_r.s_uv | sync_r.s_ov;
    end

    // assertion helper: serial rises seen in the current frame
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I || frame_start) edges_r <= HBD_EDGE_RST;
        else if (in_frame && sclk_rise) edges_r <= edges_r + 8'h01;
    end

    default clocking hbd_cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    sequence lockout_held;
        lockout && awake;
    endsequence

    sequence lockout_ended;
        !lockout && awake && (tsd_lat_r | ocs_lat_r | uld_off_r) == HBD_BR_RST;
    endsequence

    frame_length_a: assert property (
        commit |-> (edges_r[3:0] == 4'h0) && (edges_r != 8'h00))
        else $error("command taken from a frame that is not a multiple of 16 bits");

    so_window_a: assert property (
        $rose(SO_OE_O) |-> $past(cs_fall) && !sync_r.csn)
        else $error("serial output enabled without chip select falling");

    sleep_quiet_a: assert property (
        !awake |=> (BRIDGE_OUTPUT_EN_O == HBD_BR_RST) && !SO_OE_O && (state_r == HBD_SLEEP))
        else $error("device active while enable is low");

    srr_clear_a: assert property (
        commit && rx_r[CMD_SRR_BIT] |=>
            ((tsd_lat_r | ocs_lat_r) & ~$past(sync_r.thermal_shutdown_flag | sync_r.overcurrent_flag)
             & grp_mask($past(rx_r[CMD_SEL_BIT]))) == HBD_BR_RST)
        else $error("status reset left a latched fault in the selected group");

    group_write_a: assert property (
        commit |=> ((cfg_en_r ^ grp_place($past(rx_r[CMD_SEL_BIT]),
                     $past(rx_r[CMD_EN_LSB +: 6]))) & grp_mask($past(rx_r[CMD_SEL_BIT])))
                   == HBD_BR_RST)
        else $error("enable bits not written to the selected group");

    prev_group_a: assert property (
        frame_start |=> tx_r[STA_OST_LSB +: 6] == grp_pick($past(sel_r),
                                                            $past(BRIDGE_OUTPUT_EN_O)))
        else $error("status reports the wrong channel group");

    tsd_report_a: assert property (
        frame_start && (tsd_lat_r != HBD_BR_RST) |=> tx_r[STA_TSD_BIT])
        else $error("thermal shutdown not reported");

    fault_off_a: assert property (
        (tsd_lat_r | ocs_lat_r | uld_off_r) != HBD_BR_RST |=>
            (BRIDGE_OUTPUT_EN_O & $past(tsd_lat_r | ocs_lat_r | uld_off_r)) == HBD_BR_RST)
        else $error("faulted bridge left enabled");

    psf_report_a: assert property (
        frame_start && (sync_r.s_uv || sync_r.s_ov) |=> tx_r[STA_PSF_BIT])
        else $error("supply fail not reported");

    lockout_off_a: assert property (
        lockout_held |=> BRIDGE_OUTPUT_EN_O == HBD_BR_RST)
        else $error("outputs active during supply lockout");

    ov_ignored_a: assert property (
        awake && !sync_r.s_uv && !overvoltage_lockout_enable_r |=> BRIDGE_OUTPUT_EN_O ==
            $past(cfg_en_r & ~(tsd_lat_r | ocs_lat_r | uld_off_r)))
        else $error("overvoltage acted with lockout disabled");

    recover_a: assert property (
        lockout_held ##1 lockout_ended |=> BRIDGE_OUTPUT_EN_O == $past(cfg_en_r))
        else $error("outputs did not resume configuration after lockout");

    uld_mode_a: assert property (
        1'b1 |=> ((uld_off_r & ~$past(uld_off_r)) & ~$past(underload_shutdown_enable_mask)) == HBD_BR_RST)
        else $error("underload shut a bridge with shutdown disabled");

    refused_frame_a: assert property (
        in_frame && awake && cs_rise && !(got16_r && cnt_r == HBD_CNT_RST) |=>
            cfg_en_r == $past(cfg_en_r) && sel_r == $past(sel_r))
        else $error("configuration taken from a refused frame");

    so_close_a: assert property (
        in_frame && awake && cs_rise |=> !SO_OE_O)
        else $error("serial output still enabled after chip select rose");

    sample_rise_a: assert property (
        in_frame && awake && sclk_rise |=> rx_r[0] == $past(sync_r.si))
        else $error("serial input not sampled on serial clock rise");

    shift_fall_a: assert property (
        in_frame && awake && sclk_fall |=> SO_O == $past(tx_r[14]))
        else $error("serial output not advanced on serial clock fall");

    config_drive_a: assert property (
        1'b1 |=> BRIDGE_OUTPUT_HIGH_O == $past(cfg_hi_r))
        else $error("output level does not follow configuration");

    warn_report_a: assert property (
        1'b1 |=> THERMAL_WARNING_O == $past(sync_r.tw && awake))
        else $error("thermal warning not reported");

    lockout_cfg_a: assert property (
        commit && lockout |=> ((cfg_hi_r ^ grp_place($past(rx_r[CMD_SEL_BIT]),
                   $past(rx_r[CMD_CNF_LSB +: 6]))) & grp_mask($past(rx_r[CMD_SEL_BIT])))
                 == HBD_BR_RST)
        else $error("configuration refused during supply lockout");

    srr_scope_a: assert property (
        commit && rx_r[CMD_SRR_BIT] |=>
            ((tsd_lat_r ^ $past(tsd_lat_r)) & ~$past(sync_r.thermal_shutdown_flag)
             & ~grp_mask($past(rx_r[CMD_SEL_BIT]))) == HBD_BR_RST)
        else $error("status reset reached the other channel group");

endmodule // hbd_spi_fault

// ### sim/hbd_host.sv
// serial host model: chip select, serial clock and data frames for the fault controller
// assumes the bench clock at 100 MHz and a device that may be awake or asleep
module hbd_host (
    input  wire logic clk_i,
    input  wire logic so_i,
    input  wire logic so_oe_i,
    output logic      csn_o,
    output logic      sclk_o,
    output logic      si_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        csn_o  = 1'b1;
        sclk_o = 1'b0;
        si_o   = 1'b0;
    end

    // nb bits msb first, command repeated past 16 (daisy chain); half clocks high, half low
    // a released serial output reads inverted so a missing drive shows up
    task automatic frame(input logic [15:0] cmd, output logic [15:0] sta, output logic oe,
                         input int half, input int nb);
        @(posedge clk_i);
        csn_o <= 1'b0;
        si_o  <= cmd[15];
        repeat (6) @(posedge clk_i);
        for (int k = 0; k < nb; k++) begin
            @(negedge clk_i);
            if (k < 16) begin
                sta[15 - k] = so_oe_i ? so_i : ~so_i;
            end
            if (k == 0) begin
                oe = so_oe_i;
            end
            @(posedge clk_i);
            sclk_o <= 1'b1;
            repeat (half) @(posedge clk_i);
            sclk_o <= 1'b0;
            si_o   <= cmd[(30 - k) % 16];
            repeat (half - 1) @(posedge clk_i);
        end
        csn_o <= 1'b1;
        si_o  <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask
endmodule // hbd_host

// ### sim/tb_hbd_spi_fault.sv
// self-checking bench for the half-bridge serial fault controller
// assumes hbd_host drives the serial pins; fault pins change at clock rise
module tb_hbd_spi_fault
    import hbd_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, rst_n, en, ov, uv, tw_i, csn, sclk, si, so, so_oe, tw_o, oe;
    logic [11:0] tsd_i, ocs_i, uld_i, br_en, br_hi;
    logic [11:0] m_en, m_cnf, m_tsd, m_ocs, m_uld, m_off;
    logic [1:0]  m_underload_shutdown_enable;
    logic        m_sel, m_overvoltage_lockout_enable;
    logic [15:0] sta;
    int          fails = 0;
    int          tests_run = 0;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    hbd_spi_fault i_dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .EN_I(en), .CHIP_SELECT_N_I(csn),
        .SCLK_I(sclk), .SI_I(si), .SUPPLY_OVERVOLTAGE_I(ov), .SUPPLY_UNDERVOLTAGE_I(uv),
        .THERMAL_WARNING_I(tw_i), .THERMAL_FAULT_I(tsd_i), .OVERCURRENT_I(ocs_i),
        .UNDERLOAD_I(uld_i), .SO_O(so), .SO_OE_O(so_oe), .BRIDGE_OUTPUT_EN_O(br_en),
        .BRIDGE_OUTPUT_HIGH_O(br_hi), .THERMAL_WARNING_O(tw_o));

    hbd_host i_host (.clk_i(clk), .so_i(so), .so_oe_i(so_oe), .csn_o(csn), .sclk_o(sclk),
        .si_o(si));

    function automatic logic [11:0] exp_en();
        return m_en & ~(m_tsd | m_ocs | m_off) & {12{~(uv | (ov & m_overvoltage_lockout_enable))}};
    endfunction

    function automatic logic [15:0] exp_sta();
        logic [11:0] e;
        int          s;
        e = exp_en();
        s = m_sel ? 6 : 0;
        return {|m_tsd, |((m_ocs >> s) & 12'h03F), |((m_uld >> s) & 12'h03F), e[s+:6],
                m_cnf[s+:6], uv | ov};
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        if (fails == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic clr_model();
        {m_en, m_cnf, m_tsd, m_ocs, m_uld, m_off, m_underload_shutdown_enable, m_sel, m_overvoltage_lockout_enable} = '0;
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one frame; status checked against the previous selection, then outputs checked
    task automatic send(input logic [15:0] cmd, input int nb = 16);
        logic [15:0] e;
        logic [11:0] g;
        e = exp_sta();
        i_host.frame(cmd, sta, oe, 4, nb);
        g = cmd[CMD_SEL_BIT] ? HBD_HI_GRP : HBD_LO_GRP;
        chk({15'h0000, oe}, {15'h0000, en});
        if (en) begin
            chk(sta, e);
        end
        if (en && (nb % 16 == 0)) begin
            if (cmd[CMD_SRR_BIT]) begin
                m_tsd &= ~g;
                m_ocs &= ~g;
                m_uld &= ~g;
                m_off &= ~g;
            end
            m_en  = (m_en & ~g) | (g & {cmd[12:7], cmd[12:7]});
            m_cnf = (m_cnf & ~g) | (g & {cmd[6:1], cmd[6:1]});
            m_underload_shutdown_enable[cmd[CMD_SEL_BIT]] = cmd[CMD_UNDERLOAD_SHUTDOWN_ENABLE_BIT];
            m_overvoltage_lockout_enable = cmd[CMD_OVERVOLTAGE_LOCKOUT_ENABLE_BIT];
            m_sel  = cmd[CMD_SEL_BIT];
        end
        wait_clk(4);
        chk({4'h0, br_en}, {4'h0, exp_en()});
        chk({4'h0, br_hi}, {4'h0, m_cnf});
        chk({15'h0000, so_oe}, 16'h0000);
    endtask

    // pulse a fault: 0 thermal, 1 overcurrent, 2 underload
    task automatic hit(input int k, input logic [11:0] b);
        tsd_i <= (k == 0) ? b : 12'h000;
        ocs_i <= (k == 1) ? b : 12'h000;
        uld_i <= (k == 2) ? b : 12'h000;
        wait_clk(4);
        {tsd_i, ocs_i, uld_i} <= '0;
        wait_clk(4);
        m_tsd |= (k == 0) ? b : 12'h000;
        m_ocs |= (k == 1) ? b : 12'h000;
        m_uld |= (k == 2) ? b : 12'h000;
        m_off |= (k == 2) ? b & {{6{m_underload_shutdown_enable[1]}}, {6{m_underload_shutdown_enable[0]}}} : 12'h000;
        chk({4'h0, br_en}, {4'h0, exp_en()});
    endtask

    initial begin
        {rst_n, ov, uv, tw_i, tsd_i, ocs_i, uld_i} = '0;
        en = 1'b1;
        clr_model();
        void'($urandom(32'h5B1A0940));
        wait_clk(2);
        rst_n <= 1'b1;
        wait_clk(10);
        repeat (8) send(16'($urandom) & 16'h5FFF);
        send(16'h5FFE);
        send(16'h1FFE);
        send(16'h5F80, 32);
        send(16'hC000, 24);
        hit(0, 12'h800);
        hit(1, 12'h002);
        send(16'h5FFE);
        send(16'hDFFE);
        send(16'h9FFE);
        hit(2, 12'h004);
        send(16'h3FFE);
        hit(2, 12'h008);
        send(16'h3FFE);
        send(16'h9FFE);
        uv <= 1'b1;
        wait_clk(6);
        chk({4'h0, br_en}, 16'h0000);
        send(16'h1F80);
        uv <= 1'b0;
        wait_clk(6);
        chk({4'h0, br_en}, {4'h0, exp_en()});
        ov <= 1'b1;
        wait_clk(6);
        chk({4'h0, br_en}, {4'h0, exp_en()});
        send(16'h1F81);
        send(16'h1F81);
        ov <= 1'b0;
        wait_clk(6);
        chk({4'h0, br_en}, {4'h0, exp_en()});
        tw_i <= 1'b1;
        wait_clk(6);
        chk({15'h0000, tw_o}, 16'h0001);
        chk({4'h0, br_en}, {4'h0, exp_en()});
        tw_i <= 1'b0;
        en <= 1'b0;
        wait_clk(8);
        clr_model();
        chk({3'h0, tw_o, br_en}, 16'h0000);
        send(16'h5FFE);
        en <= 1'b1;
        wait_clk(8);
        repeat (3) send(16'($urandom) & 16'h5FFF);
        complete_run();
    end

    initial begin
        #400000;
        fails++;
        complete_run();
    end
endmodule // tb_hbd_spi_fault
